// >>> src/tmc_pkg.sv
`default_nettype none
package tmc_pkg;

	// ---------------------------------------------
	// register offsets (byte addresses)
	// ---------------------------------------------
	localparam logic [7:0] OFS_CTRL  = 8'h00;
	localparam logic [7:0] OFS_STAT  = 8'h04;
	localparam logic [7:0] OFS_CMPA  = 8'h08;
	localparam logic [7:0] OFS_CMPB  = 8'h0C;
	localparam logic [7:0] OFS_INTV  = 8'h10;
	localparam logic [7:0] OFS_DIV   = 8'h20;
	localparam logic [7:0] OFS_PULSE = 8'h30;
	localparam logic [7:0] OFS_WDOG  = 8'h40;
	localparam logic [7:0] OFS_CFG   = 8'h50;
	localparam logic [7:0] OFS_READ  = 8'hF0;

	// ---------------------------------------------
	// field positions
	// ---------------------------------------------
	localparam int IEN_BIT   = 15;
	localparam int ACLR_BIT  = 0;
	localparam int BEN_BIT   = 15;
	localparam int AEN_BIT   = 14;
	localparam int FFI_BIT   = 0;
	localparam int WEN_BIT   = 15;
	localparam int ARM_BIT   = 7;
	localparam int KICK_BIT  = 0;
	localparam int ROUTE_BIT = 0;
	localparam int IFLAG     = 0;
	localparam int AFLAG     = 1;
	localparam int BFLAG     = 2;
	localparam int WFLAG     = 3;
	localparam int CNT_W     = 24;

	// ---------------------------------------------
	// reset values
	// ---------------------------------------------
	localparam logic [7:0]  CTRL_RST = 8'h00;
	localparam logic [3:0]  FLAG_RST = 4'h0;
	localparam logic [23:0] CMP_RST  = 24'h00_0000;
	localparam logic [2:0]  DIV_RST  = 3'h0;

	typedef enum logic [1:0] {
		MODE_INTERVAL = 2'h0,
		MODE_PULSE    = 2'h1,
		MODE_WDOG     = 2'h2,
		MODE_OFF      = 2'h3
	} tmc_mode_t;

	typedef struct packed {
		logic      run;
		logic      preEn;
		logic      haltClr;
		logic      rsv;
		logic      edgeRise;
		logic      extSel;
		tmc_mode_t mode;
	} tmc_ctrl_t;

endpackage
`default_nettype wire

// >>> src/tmc_timer.sv
`timescale 1ns/1ps
`default_nettype none
module tmc_timer #(
	parameter int CHAN = 2
) (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// avalon-mm slave
	input  wire logic [7:0]  address,
	input  wire logic        read,
	input  wire logic        write,
	input  wire logic [31:0] writedata,
	input  wire logic [3:0]  byteenable,
	output logic      [31:0] readdata,
	output logic             waitrequest,
	// external count clock pin
	input  wire logic        extClk,
	// outputs
	output logic             pulseOut,
	output logic             timerIrqN,
	output logic             wdNmiN,
	output logic             wdRstN
);

	// ---------------------------------------------
	// bus slave
	// ---------------------------------------------
	function automatic logic [31:0] beMerge(
		input logic [31:0] old,
		input logic [31:0] wd,
		input logic [3:0]  be
	);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i])
				r[8*i +: 8] = wd[8*i +: 8];
		end
		return r;
	endfunction

	logic                   waitReq_reg;
	logic [31:0]            rdData_reg;
	logic [31:0]            rdMux;
	logic                   busWr;
	logic                   wrCtrl, wrStat, wrCmpA, wrCmpB;
	logic                   wrIntv, wrDiv, wrPulse, wrWdog, wrCfg;

	tmc_pkg::tmc_ctrl_t     ctrl_reg;
	tmc_pkg::tmc_ctrl_t     ctrlNew;
	logic [31:0]            ctrlM;
	logic [3:0]             flag_reg;
	logic [3:0]             flagSet;
	logic [3:0]             flagClr;
	logic [23:0]            cmpA_reg, cmpB_reg, cnt_reg;
	logic                   ien_reg, aclr_reg;
	logic [2:0]             div_reg;
	logic                   ben_reg, aen_reg, ffi_reg;
	logic                   wen_reg, arm_reg, kick_reg;
	logic                   route_reg;
	logic                   stop_reg;
	logic                   pulse_reg;

	// one wait cycle, then a single acknowledge cycle
	always_ff @(posedge clk) begin
		if (rst)
			waitReq_reg <= 1'b1;
		else
			waitReq_reg <= !((read || write) && waitReq_reg);
	end
	assign waitrequest = waitReq_reg;
	assign busWr       = write && !waitReq_reg;

	always_comb begin
		wrCtrl  = busWr && (address == tmc_pkg::OFS_CTRL);
		wrStat  = busWr && (address == tmc_pkg::OFS_STAT);
		wrCmpA  = busWr && (address == tmc_pkg::OFS_CMPA);
		wrCmpB  = busWr && (address == tmc_pkg::OFS_CMPB);
		wrIntv  = busWr && (address == tmc_pkg::OFS_INTV);
		wrDiv   = busWr && (address == tmc_pkg::OFS_DIV);
		wrPulse = busWr && (address == tmc_pkg::OFS_PULSE);
		wrWdog  = busWr && (address == tmc_pkg::OFS_WDOG);
		wrCfg   = busWr && (address == tmc_pkg::OFS_CFG);
	end

	always_comb begin
		rdMux = 32'h0000_0000;
		if (address == tmc_pkg::OFS_CTRL)
			rdMux[7:0] = ctrl_reg;
		else if (address == tmc_pkg::OFS_STAT)
			rdMux[3:0] = flag_reg;
		else if (address == tmc_pkg::OFS_CMPA)
			rdMux[23:0] = cmpA_reg;
		else if (address == tmc_pkg::OFS_CMPB)
			rdMux[23:0] = cmpB_reg;
		else if (address == tmc_pkg::OFS_INTV) begin
			rdMux[tmc_pkg::IEN_BIT]  = ien_reg;
			rdMux[tmc_pkg::ACLR_BIT] = aclr_reg;
		end else if (address == tmc_pkg::OFS_DIV)
			rdMux[2:0] = div_reg;
		else if (address == tmc_pkg::OFS_PULSE) begin
			rdMux[tmc_pkg::BEN_BIT] = ben_reg;
			rdMux[tmc_pkg::AEN_BIT] = aen_reg;
			rdMux[tmc_pkg::FFI_BIT] = ffi_reg;
		end else if (address == tmc_pkg::OFS_WDOG) begin
			rdMux[tmc_pkg::WEN_BIT]  = wen_reg;
			rdMux[tmc_pkg::ARM_BIT]  = arm_reg;
			rdMux[tmc_pkg::KICK_BIT] = kick_reg;
		end else if (address == tmc_pkg::OFS_CFG)
			rdMux[tmc_pkg::ROUTE_BIT] = route_reg;
		else if (address == tmc_pkg::OFS_READ)
			rdMux[23:0] = cnt_reg;
	end

	always_ff @(posedge clk) begin
		if (rst)
			rdData_reg <= 32'h0000_0000;
		else if (read && waitReq_reg)
			rdData_reg <= rdMux;
	end
	assign readdata = rdData_reg;

	// ---------------------------------------------
	// control register
	// ---------------------------------------------
	logic wdMode, wdCtrlOff, wdIrqOff, haltClr;

	assign ctrlM   = beMerge({24'h00_0000, ctrl_reg}, writedata,
		byteenable);
	assign ctrlNew = tmc_pkg::tmc_ctrl_t'(ctrlM[7:0]);
	assign wdMode  = (CHAN == 2) &&
		(ctrl_reg.mode == tmc_pkg::MODE_WDOG);
	assign wdCtrlOff = wrCtrl && wdMode && arm_reg &&
		ctrl_reg.run && !ctrlNew.run;
	assign wdIrqOff = wrWdog && wdMode && arm_reg && wen_reg &&
		byteenable[1] && !writedata[tmc_pkg::WEN_BIT];
	assign haltClr = wrCtrl && ctrl_reg.run && !ctrlNew.run &&
		ctrlNew.haltClr && !(wdMode && !arm_reg);

	always_ff @(posedge clk) begin
		if (rst)
			ctrl_reg <= tmc_pkg::tmc_ctrl_t'(tmc_pkg::CTRL_RST);
		else if (wrCtrl) begin
			ctrl_reg     <= ctrlNew;
			ctrl_reg.rsv <= 1'b0;
			if (CHAN == 0)
				ctrl_reg.extSel <= 1'b0;
			if (wdMode && !arm_reg && ctrl_reg.run)
				ctrl_reg.run <= 1'b1;
		end
	end

	// ---------------------------------------------
	// mode registers
	// ---------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			cmpA_reg <= tmc_pkg::CMP_RST;
			cmpB_reg <= tmc_pkg::CMP_RST;
			div_reg  <= tmc_pkg::DIV_RST;
			route_reg <= 1'b0;
		end else begin
			if (wrCmpA)
				cmpA_reg <= 24'(beMerge({8'h00, cmpA_reg}, writedata,
					byteenable));
			if (wrCmpB)
				cmpB_reg <= 24'(beMerge({8'h00, cmpB_reg}, writedata,
					byteenable));
			if (wrDiv && byteenable[0])
				div_reg <= writedata[2:0];
			if (wrCfg && byteenable[0])
				route_reg <= writedata[tmc_pkg::ROUTE_BIT];
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			ien_reg  <= 1'b0;
			aclr_reg <= 1'b0;
			ben_reg  <= 1'b0;
			aen_reg  <= 1'b0;
			ffi_reg  <= 1'b0;
		end else begin
			if (wrIntv && byteenable[1])
				ien_reg <= writedata[tmc_pkg::IEN_BIT];
			if (wrIntv && byteenable[0])
				aclr_reg <= writedata[tmc_pkg::ACLR_BIT];
			if (wrPulse && byteenable[1]) begin
				ben_reg <= writedata[tmc_pkg::BEN_BIT];
				aen_reg <= writedata[tmc_pkg::AEN_BIT];
			end
			if (wrPulse && byteenable[0])
				ffi_reg <= writedata[tmc_pkg::FFI_BIT];
		end
	end

	// watchdog register: enable, arm, kick
	always_ff @(posedge clk) begin
		if (rst) begin
			wen_reg  <= 1'b0;
			arm_reg  <= 1'b0;
			kick_reg <= 1'b0;
		end else begin
			if (wrWdog && byteenable[1] &&
				(writedata[tmc_pkg::WEN_BIT] || arm_reg))
				wen_reg <= writedata[tmc_pkg::WEN_BIT];
			if (wdCtrlOff || wdIrqOff)
				arm_reg <= 1'b0;
			else if (wrWdog && byteenable[0] &&
				writedata[tmc_pkg::ARM_BIT])
				arm_reg <= 1'b1;
			if (kick_reg)
				kick_reg <= 1'b0;
			else if (wrWdog && byteenable[0] &&
				writedata[tmc_pkg::KICK_BIT])
				kick_reg <= 1'b1;
		end
	end

	// ---------------------------------------------
	// count clock
	// ---------------------------------------------
	logic [7:0] pre_reg;
	logic [8:0] preM;
	logic       sync1_reg, sync2_reg, sync3_reg;
	logic       intTick, extTick, tick;

	always_ff @(posedge clk) begin
		if (rst || !ctrl_reg.preEn || !ctrl_reg.run)
			pre_reg <= 8'h00;
		else
			pre_reg <= pre_reg + 8'h01;
	end
	assign preM = (9'h002 << div_reg) - 9'h001;
	// falling edge of the divided clock
	assign intTick = ctrl_reg.preEn ?
		((pre_reg & preM[7:0]) == preM[7:0]) : 1'b1;

	always_ff @(posedge clk) begin
		if (rst) begin
			sync1_reg <= 1'b0;
			sync2_reg <= 1'b0;
			sync3_reg <= 1'b0;
		end else begin
			sync1_reg <= extClk;
			sync2_reg <= sync1_reg;
			sync3_reg <= sync2_reg;
		end
	end
	assign extTick = ctrl_reg.edgeRise ?
		(sync2_reg && !sync3_reg) :
		(!sync2_reg && sync3_reg);
	assign tick = (ctrl_reg.extSel && CHAN != 0) ?
		extTick : intTick;

	// ---------------------------------------------
	// counter and match logic
	// ---------------------------------------------
	logic modeOk, active, matchA, matchB, resume;
	logic [23:0] cntInc;

	always_comb begin
		case (ctrl_reg.mode)
			tmc_pkg::MODE_INTERVAL: modeOk = 1'b1;
			tmc_pkg::MODE_PULSE:    modeOk = (CHAN != 0);
			tmc_pkg::MODE_WDOG:     modeOk = (CHAN == 2);
			default:                modeOk = 1'b0;
		endcase
	end
	assign active = ctrl_reg.run && !stop_reg && modeOk && tick;
	// match on the value this tick loads: a clear replaces that count
	assign cntInc = cnt_reg + 24'h00_0001;
	assign matchA = active && (cntInc == cmpA_reg);
	assign matchB = active && (cntInc == cmpB_reg);
	assign resume = stop_reg && flagClr[tmc_pkg::IFLAG] &&
		aclr_reg;

	always_comb begin
		flagSet = 4'h0;
		case (ctrl_reg.mode)
			tmc_pkg::MODE_INTERVAL:
				flagSet[tmc_pkg::IFLAG] = matchA;
			tmc_pkg::MODE_PULSE: begin
				flagSet[tmc_pkg::AFLAG] = matchA && !matchB;
				flagSet[tmc_pkg::BFLAG] = matchB && ben_reg;
			end
			tmc_pkg::MODE_WDOG:
				flagSet[tmc_pkg::WFLAG] = matchA;
			default:
				flagSet = 4'h0;
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			cnt_reg  <= 24'h00_0000;
			stop_reg <= 1'b0;
		end else if (kick_reg || haltClr || resume) begin
			cnt_reg  <= 24'h00_0000;
			stop_reg <= 1'b0;
		end else if (!ctrl_reg.run) begin
			stop_reg <= 1'b0;
		end else if (active) begin
			case (ctrl_reg.mode)
				tmc_pkg::MODE_INTERVAL: begin
					if (matchA && aclr_reg)
						cnt_reg <= 24'h00_0000;
					else if (matchA) begin
						cnt_reg  <= cntInc;
						stop_reg <= 1'b1;
					end else
						cnt_reg <= cntInc;
				end
				tmc_pkg::MODE_PULSE: begin
					if (matchB)
						cnt_reg <= 24'h00_0000;
					else
						cnt_reg <= cntInc;
				end
				default:
					cnt_reg <= cntInc;
			endcase
		end
	end

	// status flags: a set beats a clear in the same cycle
	assign flagClr = (wrStat && byteenable[0]) ?
		~writedata[3:0] : 4'h0;

	always_ff @(posedge clk) begin
		if (rst)
			flag_reg <= tmc_pkg::FLAG_RST;
		else
			flag_reg <= (flag_reg & ~flagClr) | flagSet;
	end

	// ---------------------------------------------
	// pulse flip-flop and request outputs
	// ---------------------------------------------
	always_ff @(posedge clk) begin
		if (rst)
			pulse_reg <= 1'b0;
		else if (wrPulse && byteenable[0])
			pulse_reg <= writedata[tmc_pkg::FFI_BIT];
		else if (ctrl_reg.mode == tmc_pkg::MODE_PULSE &&
			(matchA || matchB))
			pulse_reg <= !pulse_reg;
	end
	assign pulseOut = pulse_reg;

	logic tIrq_reg, nmi_reg, wrst_reg, wdReq;
	assign wdReq = (CHAN == 2) && flag_reg[tmc_pkg::WFLAG] && wen_reg;

	always_ff @(posedge clk) begin
		if (rst) begin
			tIrq_reg <= 1'b1;
			nmi_reg  <= 1'b1;
			wrst_reg <= 1'b1;
		end else begin
			tIrq_reg <= !((flag_reg[tmc_pkg::IFLAG] && ien_reg) ||
				(flag_reg[tmc_pkg::AFLAG] && aen_reg) ||
				flag_reg[tmc_pkg::BFLAG]);
			nmi_reg  <= !(wdReq && !route_reg);
			wrst_reg <= !(wdReq && route_reg);
		end
	end
	assign timerIrqN = tIrq_reg;
	assign wdNmiN    = nmi_reg;
	assign wdRstN    = wrst_reg;

	// ---------------------------------------------
	// assertions
	// ---------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	property p_intSet;
		matchA && ctrl_reg.mode == tmc_pkg::MODE_INTERVAL
			|=> flag_reg[tmc_pkg::IFLAG];
	endproperty
	a_intSet: assert property (p_intSet)
		else $error("interval flag not set on match");

	property p_aclr;
		matchA && aclr_reg && !kick_reg && !haltClr &&
			ctrl_reg.mode == tmc_pkg::MODE_INTERVAL
			|=> cnt_reg == 24'h00_0000 ##1 !tIrq_reg || !ien_reg;
	endproperty
	a_aclr: assert property (p_aclr)
		else $error("autoclear match did not zero counter");

	property p_hold;
		matchA && !aclr_reg && !kick_reg && !haltClr &&
			ctrl_reg.mode == tmc_pkg::MODE_INTERVAL
			|=> stop_reg && cnt_reg == $past(cmpA_reg);
	endproperty
	a_hold: assert property (p_hold)
		else $error("counter did not stop on match");

	property p_flagClr;
		wrStat && byteenable[0] && !writedata[0] && !flagSet[0]
			|=> !flag_reg[0] ##1 tIrq_reg || flag_reg[1];
	endproperty
	a_flagClr: assert property (p_flagClr)
		else $error("flag clear failed");

	property p_pulseB;
		matchB && ctrl_reg.mode == tmc_pkg::MODE_PULSE &&
			!kick_reg && !haltClr && !wrPulse
			|=> cnt_reg == 24'h00_0000 && pulse_reg != $past(pulse_reg);
	endproperty
	a_pulseB: assert property (p_pulseB)
		else $error("compare B did not toggle and clear");

	property p_kick;
		kick_reg |=> cnt_reg == 24'h00_0000 && !kick_reg;
	endproperty
	a_kick: assert property (p_kick)
		else $error("kick did not clear counter");

	property p_wdHold;
		wrCtrl && wdMode && !arm_reg && ctrl_reg.run
			|=> ctrl_reg.run;
	endproperty
	a_wdHold: assert property (p_wdHold)
		else $error("watchdog halted while not armed");

	property p_wenKeep;
		wen_reg && !arm_reg && wrWdog |=> wen_reg;
	endproperty
	a_wenKeep: assert property (p_wenKeep)
		else $error("watchdog irq enable cleared while not armed");

	property p_ffLoad;
		wrPulse && byteenable[0]
			|=> pulse_reg == $past(writedata[tmc_pkg::FFI_BIT]);
	endproperty
	a_ffLoad: assert property (p_ffLoad)
		else $error("flop not loaded with initial level");

	property p_readback;
		read && waitReq_reg && address == tmc_pkg::OFS_READ
			|=> readdata == {8'h00, $past(cnt_reg)} && !waitrequest;
	endproperty
	a_readback: assert property (p_readback)
		else $error("readback differs from counter");

	c_intMatch: cover property (flagSet[tmc_pkg::IFLAG] && aclr_reg);
	c_pulseB:   cover property (flagSet[tmc_pkg::BFLAG]);
	c_wdNmi:    cover property ($fell(wdNmiN));
	c_wdOff:    cover property (wdCtrlOff);

endmodule
`default_nettype wire

// >>> sim/tmc_bus_master.sv
`timescale 1ns/1ps
`default_nettype none
module tmc_bus_master (
	// clock
	input  wire logic        clk,
	// avalon-mm master
	output logic      [7:0]  address,
	output logic             read,
	output logic             write,
	output logic      [31:0] writedata,
	output logic      [3:0]  byteenable,
	input  wire logic [31:0] readdata,
	input  wire logic        waitrequest,
	// status
	output logic             hung
);
	initial begin
		address = 8'h00;
		read = 1'b0;
		write = 1'b0;
		writedata = 32'h0000_0000;
		byteenable = 4'h0;
		hung = 1'b0;
	end

	// request held until waitrequest sampled low
	task automatic xfer(input logic wr, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q);
		int n;
		n = 0;
		@(posedge clk);
		address <= a;
		writedata <= d;
		byteenable <= 4'hF;
		read <= !wr;
		write <= wr;
		do begin
			@(posedge clk);
			n++;
		end while (waitrequest !== 1'b0 && n < 64);
		q = readdata;
		if (waitrequest !== 1'b0) begin
			hung <= 1'b1;
		end
		read <= 1'b0;
		write <= 1'b0;
	endtask
endmodule
`default_nettype wire

// >>> sim/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic        clk;
	logic        rst;
	logic [7:0]  address;
	logic        read;
	logic        write;
	logic [31:0] writedata;
	logic [3:0]  byteenable;
	logic [31:0] readdata;
	logic        waitrequest;
	logic        extClk;
	logic        pulseOut;
	logic        timerIrqN;
	logic        wdNmiN;
	logic        wdRstN;
	logic        hung;
	logic        lastP;
	logic [3:0]  pinV;
	logic [32:0] expQ[$];
	logic [32:0] e;
	logic [31:0] rv;
	logic [31:0] rvA;
	logic [31:0] seed;
	logic [31:0] cmpV;
	int          n_errors;
	int          num_checks;
	int          cyc;
	int          tog;
	int          dv;

	tmc_timer #(.CHAN(2)) tmc_timer_i (.clk(clk), .rst(rst),
		.address(address), .read(read), .write(write),
		.writedata(writedata), .byteenable(byteenable),
		.readdata(readdata), .waitrequest(waitrequest), .extClk(extClk),
		.pulseOut(pulseOut), .timerIrqN(timerIrqN), .wdNmiN(wdNmiN),
		.wdRstN(wdRstN));

	tmc_bus_master tmc_bus_master_i (.clk(clk), .address(address),
		.read(read), .write(write), .writedata(writedata),
		.byteenable(byteenable), .readdata(readdata),
		.waitrequest(waitrequest), .hung(hung));

	assign pinV = {wdRstN, wdNmiN, timerIrqN, pulseOut};

	initial clk = 1'b0;
	always #12.5 clk = ~clk;

	// ---------------------------------------------
	// helpers
	// ---------------------------------------------
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	task automatic end_sim;
		$display("checks=%0d errors=%0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chkr(input logic [31:0] got, input logic [31:0] lo,
		input logic [31:0] hi);
		num_checks++;
		if ((got >= lo && got <= hi) !== 1'b1) begin
			n_errors++;
			$display("[FAIL] t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		tmc_bus_master_i.xfer(1'b1, a, d, rv);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] x);
		expQ.push_back({1'b1, x});
		tmc_bus_master_i.xfer(1'b0, a, 32'h0000_0000, rv);
	endtask

	task automatic rdv(input logic [7:0] a);
		expQ.push_back({1'b0, 32'h0000_0000});
		tmc_bus_master_i.xfer(1'b0, a, 32'h0000_0000, rv);
	endtask

	task automatic wpin(input int s, input logic l, input int bnd);
		cyc = 0;
		while (pinV[s] !== l) begin
			@(posedge clk);
			cyc++;
			if (cyc > bnd) begin
				n_errors++;
				$display("[FAIL] t=%0t pin=%h exp=%h", $time, s, l);
				end_sim;
			end
		end
	endtask

	task automatic pulses(input int n);
		repeat (n) begin
			repeat (4) @(posedge clk);
			extClk <= 1'b1;
			repeat (4) @(posedge clk);
			extClk <= 1'b0;
		end
		repeat (6) @(posedge clk);
	endtask

	// ---------------------------------------------
	// read monitor: oldest note against each read
	// ---------------------------------------------
	always @(posedge clk) begin
		if (read && waitrequest === 1'b0 && expQ.size() > 0) begin
			e = expQ.pop_front();
			if (e[32]) begin
				chk(readdata, e[31:0]);
			end
		end
	end

	always @(posedge hung) begin
		n_errors++;
		$display("[FAIL] t=%0t got=%h exp=%h", $time, 1, 0);
		end_sim;
	end

	// ---------------------------------------------
	// main sequence
	// ---------------------------------------------
	initial begin
		rst = 1'b1;
		extClk = 1'b0;
		seed = 32'h0000_BC49;
		n_errors = 0;
		num_checks = 0;
		lastP = 1'b0;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		rd(tmc_pkg::OFS_CTRL, 32'h0000_0000);
		rd(tmc_pkg::OFS_STAT, 32'h0000_0000);
		rd(tmc_pkg::OFS_READ, 32'h0000_0000);
		rd(8'h60, 32'h0000_0000);
		chk({wdRstN, wdNmiN, timerIrqN, pulseOut}, 32'h0000_000E);
		$display("test reset done");

		for (int k = 0; k < 4; k++) begin
			wr(tmc_pkg::OFS_CMPA, 32'h0000_0003);
			wr(tmc_pkg::OFS_INTV, 32'h0000_8000 | k[0]);
			wr(tmc_pkg::OFS_CTRL, 32'h0000_0084 | (k[1] << 3));
			pulses(6);
			chk(timerIrqN, 32'h0000_0000);
			wr(tmc_pkg::OFS_CTRL, 32'h0000_0004 | (k[1] << 3));
			rdv(tmc_pkg::OFS_READ);
			if (k[0]) begin
				chk(rv, 32'h0000_0000);
			end else begin
				chk(rv, 32'h0000_0003);
			end
			rd(tmc_pkg::OFS_STAT, 32'h0000_0001);
			wr(tmc_pkg::OFS_STAT, 32'h0000_000F);
			rd(tmc_pkg::OFS_STAT, 32'h0000_0001);
			wr(tmc_pkg::OFS_STAT, 32'h0000_0000);
			repeat (2) @(posedge clk);
			chk(timerIrqN, 32'h0000_0001);
			// restart so the halt below clears the count
			wr(tmc_pkg::OFS_CTRL, 32'h0000_0084 | (k[1] << 3));
			wr(tmc_pkg::OFS_CTRL, 32'h0000_0020);
			rd(tmc_pkg::OFS_READ, 32'h0000_0000);
		end
		$display("test external clock done");

		wr(tmc_pkg::OFS_INTV, 32'h0000_0000);
		wr(tmc_pkg::OFS_CMPA, 32'h0000_0002);
		wr(tmc_pkg::OFS_CTRL, 32'h0000_0080);
		repeat (12) @(posedge clk);
		chk(timerIrqN, 32'h0000_0001);
		rd(tmc_pkg::OFS_STAT, 32'h0000_0001);
		rd(tmc_pkg::OFS_READ, 32'h0000_0002);
		wr(tmc_pkg::OFS_INTV, 32'h0000_8001);
		wr(tmc_pkg::OFS_STAT, 32'h0000_0000);
		wpin(1, 1'b1, 20);
		wpin(1, 1'b0, 20);
		wr(tmc_pkg::OFS_CTRL, 32'h0000_0020);
		wr(tmc_pkg::OFS_STAT, 32'h0000_0000);
		for (int c = 0; c < 8; c++) begin
			dv = 1 << (c + 1);
			wr(tmc_pkg::OFS_INTV, 32'h0000_8000);
			wr(tmc_pkg::OFS_DIV, c);
			wr(tmc_pkg::OFS_CTRL, 32'h0000_00C0);
			wpin(1, 1'b0, 4000);
			chkr(cyc, 2 * dv + 1, 2 * dv + 3);
			wr(tmc_pkg::OFS_CTRL, 32'h0000_0020);
			wr(tmc_pkg::OFS_STAT, 32'h0000_0000);
		end
		$display("test prescale done");

		wr(tmc_pkg::OFS_CMPA, 32'h0000_0001);
		wr(tmc_pkg::OFS_CMPB, 32'h0000_0003);
		wr(tmc_pkg::OFS_PULSE, 32'h0000_C001);
		@(posedge clk);
		chk(pulseOut, 32'h0000_0001);
		wr(tmc_pkg::OFS_CTRL, 32'h0000_0081);
		tog = 0;
		lastP = pulseOut;
		repeat (96) begin
			@(posedge clk);
			if (pulseOut !== lastP) tog++;
			lastP = pulseOut;
		end
		chkr(tog, 32'h0000_003E, 32'h0000_0040);
		rd(tmc_pkg::OFS_STAT, 32'h0000_0006);
		wr(tmc_pkg::OFS_CTRL, 32'h0000_0021);
		wr(tmc_pkg::OFS_STAT, 32'h0000_0000);
		repeat (2) @(posedge clk);
		chk(timerIrqN, 32'h0000_0001);
		$display("test pulse done");

		cmpV = 32'h0000_0020 + (xs() & 32'h0000_001F);
		wr(tmc_pkg::OFS_CFG, 32'h0000_0000);
		wr(tmc_pkg::OFS_CMPA, cmpV);
		wr(tmc_pkg::OFS_WDOG, 32'h0000_8000);
		wr(tmc_pkg::OFS_CTRL, 32'h0000_0082);
		wpin(2, 1'b0, 200);
		chk(wdRstN, 32'h0000_0001);
		rd(tmc_pkg::OFS_STAT, 32'h0000_0008);
		wr(tmc_pkg::OFS_STAT, 32'h0000_0000);
		repeat (2) @(posedge clk);
		chk(wdNmiN, 32'h0000_0001);
		wr(tmc_pkg::OFS_WDOG, 32'h0000_8001);
		rdv(tmc_pkg::OFS_READ);
		chk(rv, 32'h0000_0000);
		rd(tmc_pkg::OFS_WDOG, 32'h0000_8000);
		wr(tmc_pkg::OFS_CTRL, 32'h0000_0002);
		rdv(tmc_pkg::OFS_READ);
		rvA = rv;
		rdv(tmc_pkg::OFS_READ);
		chkr(rv, rvA + 1, rvA + 8);
		wr(tmc_pkg::OFS_WDOG, 32'h0000_0000);
		rd(tmc_pkg::OFS_WDOG, 32'h0000_8000);
		wr(tmc_pkg::OFS_WDOG, 32'h0000_8080);
		wr(tmc_pkg::OFS_CTRL, 32'h0000_0002);
		rd(tmc_pkg::OFS_WDOG, 32'h0000_8000);
		rdv(tmc_pkg::OFS_READ);
		rvA = rv;
		rdv(tmc_pkg::OFS_READ);
		chk(rv, rvA);
		wr(tmc_pkg::OFS_WDOG, 32'h0000_8080);
		wr(tmc_pkg::OFS_WDOG, 32'h0000_0000);
		rd(tmc_pkg::OFS_WDOG, 32'h0000_0000);
		wr(tmc_pkg::OFS_CFG, 32'h0000_0001);
		wr(tmc_pkg::OFS_WDOG, 32'h0000_8001);
		wr(tmc_pkg::OFS_CTRL, 32'h0000_0082);
		wpin(3, 1'b0, 200);
		chk(wdNmiN, 32'h0000_0001);
		$display("test watchdog done");
		end_sim;
	end
endmodule
`default_nettype wire
